// file: hw/fmc_hyst_if.sv
`timescale 1ns/10ps
`default_nettype none
interface fmc_hyst_if;
	logic [7:0] temp;
	logic [7:0] limit;
	logic       cycle;
	logic       clr;
	logic       srst;
	logic       flag;

	modport ctl (
		output temp,
		output limit,
		output cycle,
		output clr,
		output srst,
		input  flag
	);

	modport hyst (
		input  temp,
		input  limit,
		input  cycle,
		input  clr,
		input  srst,
		output flag
	);
endinterface
`default_nettype wire

// file: hw/fmc_pkg.sv
package fmc_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] FMC_ADDR_STATUS1 = 8'h02;
	localparam logic [7:0] FMC_ADDR_CONFIG4 = 8'h04;
	localparam logic [7:0] FMC_STATUS1_RST  = 8'h00;
	localparam logic [7:0] FMC_CONFIG4_RST  = 8'h08;
	localparam logic [7:0] FMC_RDATA_NONE   = 8'h00;

	// Config fields
	localparam int FMC_CFG_MODE_BIT = 7;
	localparam int FMC_CFG_PPR_BIT  = 6;
	localparam int FMC_CFG_FAST_BIT = 5;
	localparam int FMC_CFG_OVR_BIT  = 4;
	// Bits 3..0 are fixed: read-only pattern
	localparam logic [3:0] FMC_CFG_FIXED = 4'h8;

	// Status fields
	localparam int FMC_ST_LOW_BIT   = 7;
	localparam int FMC_ST_HIGH_BIT  = 6;
	localparam int FMC_ST_FAIL_BIT  = 5;
	localparam int FMC_ST_THERMAL_OUT_N_BIT = 4;

	// ****************************************
	// Temperature values
	// ****************************************
	localparam logic [7:0]        FMC_TEMP_FAILED = 8'h80;
	localparam logic signed [8:0] FMC_HYST_DEG    = 9'sh005;

	// ****************************************
	// Timing
	// ****************************************
	localparam int FMC_CLK_HZ       = 40_000_000;
	localparam int FMC_FAST_SPEED_REFRESH_MS = 250;
	localparam int FMC_TACH_SLOW_MS = 1000;
	localparam int FMC_FAST_SPEED_REFRESH_CYC = (FMC_CLK_HZ / 1000) * FMC_FAST_SPEED_REFRESH_MS;
	localparam int FMC_TACH_SLOW_CYC = (FMC_CLK_HZ / 1000) * FMC_TACH_SLOW_MS;
	localparam int FMC_TACH_CNT_W    = 26;

	// ****************************************
	// Status read tracking
	// ****************************************
	typedef enum logic [0:0] {
		FMC_RD_IDLE = 1'b0,
		FMC_RD_PEND = 1'b1
	} fmc_rd_state_type;

endpackage

// file: hw/fmc_tach_timer.sv
`timescale 1ns/10ps
`default_nettype none
module fmc_tach_timer
	import fmc_pkg::*;
#(
	parameter int FAST_CYC = FMC_FAST_SPEED_REFRESH_CYC,
	parameter int SLOW_CYC = FMC_TACH_SLOW_CYC
) (
	input  wire logic clk,    // Device clock
	input  wire logic arst_n, // Async reset
	input  wire logic srst,   // Software reset pulse
	input  wire logic fast,   // Fast refresh select
	output var  logic tick    // One-cycle refresh pulse
);
	localparam logic [FMC_TACH_CNT_W-1:0] FAST_LAST =
		FMC_TACH_CNT_W'(FAST_CYC - 1);
	localparam logic [FMC_TACH_CNT_W-1:0] SLOW_LAST =
		FMC_TACH_CNT_W'(SLOW_CYC - 1);

	logic [FMC_TACH_CNT_W-1:0] cnt_q;
	logic [FMC_TACH_CNT_W-1:0] cnt_d;
	logic                      tick_q;
	logic                      tick_d;
	logic [FMC_TACH_CNT_W-1:0] last;

	// A rate change takes hold at once; the count never overshoots
	always_comb begin
		last   = fast ? FAST_LAST : SLOW_LAST;
		cnt_d  = cnt_q + 1'b1;
		tick_d = 1'b0;
		if (srst) begin
			cnt_d = '0;
		end else if (cnt_q >= last) begin
			cnt_d  = '0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
endmodule
`default_nettype wire

// file: hw/fmc_thermal_out_n_hyst.sv
`timescale 1ns/10ps
`default_nettype none
module fmc_thermal_out_n_hyst
	import fmc_pkg::*;
(
	input  wire logic clk,    // Device clock
	input  wire logic arst_n, // Async reset
	fmc_hyst_if.hyst  hif     // Compare inputs and flag
);
	logic                flag_q;
	logic                flag_d;
	logic                armed_q;
	logic                armed_d;
	logic signed [8:0]   temp_s;
	logic signed [8:0]   rearm_lvl;
	logic                over;

	always_comb begin
		temp_s    = $signed({hif.temp[7], hif.temp});
		rearm_lvl = $signed({hif.limit[7], hif.limit}) - FMC_HYST_DEG;
		over      = temp_s > $signed({hif.limit[7], hif.limit});
		flag_d    = flag_q;
		armed_d   = armed_q;
		if (hif.srst) begin
			flag_d  = 1'b0;
			armed_d = 1'b1;
		end else begin
			// Clearing disarms; apart from a soft reset, only a drop to limit minus 5 or below rearms
			if (hif.clr) begin
				flag_d  = 1'b0;
				armed_d = 1'b0;
			end
			if (hif.cycle && temp_s <= rearm_lvl) begin
				armed_d = 1'b1;
			end
			// Set wins over a same-cycle clear when still armed
			if (hif.cycle && over && armed_q) begin
				flag_d = 1'b1;
				if (hif.clr) begin
					armed_d = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_q  <= 1'b0;
			armed_q <= 1'b1;
		end else begin
			flag_q  <= flag_d;
			armed_q <= armed_d;
		end
	end

	assign hif.flag = flag_q;
endmodule
`default_nettype wire

// file: hw/fmc_top.sv
`timescale 1ns/10ps
`default_nettype none
module fmc_top
	import fmc_pkg::*;
#(
	parameter int FAST_SPEED_REFRESH_CYC = FMC_FAST_SPEED_REFRESH_CYC,
	parameter int TACH_SLOW_CYC = FMC_TACH_SLOW_CYC
) (
	input  wire logic       clk,                 // 40 MHz device clock
	input  wire logic       arst_n,              // Async reset, low
	input  wire logic [7:0] reg_addr,            // Register address
	input  wire logic       reg_wr,              // Write strobe
	input  wire logic [7:0] reg_wdata,           // Write data
	input  wire logic       reg_rd,              // Read request strobe
	input  wire logic       reg_rd_done,         // Read byte returned
	output var  logic [7:0] reg_rdata,           // Read data
	input  wire logic       soft_reset,          // Software reset pulse
	input  wire logic       monitor_cycle,       // Compare results valid
	input  wire logic [7:0] local_temp,          // Local temperature
	input  wire logic [7:0] local_low_limit,     // Local low limit
	input  wire logic [7:0] local_high_limit,    // Local high limit
	input  wire logic [7:0] remote_temp_meas,    // Measured remote temp
	input  wire logic [7:0] remote_thermal_out_n_limit,  // Remote thermal limit
	input  wire logic       remote_sensor_fault, // Sensor open/short
	input  wire logic       sensor_fail_irq_en,  // Failure alert enable
	input  wire logic       thermal_over_irq_en, // Thermal alert enable
	output var  logic [7:0] remote_temp_data,    // Remote data register
	output var  logic       pulses_per_rev_sel,  // 0: two, 1: four
	output var  logic       fast_speed_refresh,  // Fast tach refresh
	output var  logic       tach_update,         // Tach refresh pulse
	output var  logic       overtemp_out_n,      // Over-temp pin level
	output var  logic       overtemp_out_oe,     // Over-temp pin enable
	output var  logic       thermal_out_n,       // Thermal pin, low
	output var  logic       alert_n              // Alert pin, low
);

	// ****************************************
	// Declarations
	// ****************************************
	logic [3:0]       cfg_q;
	logic [3:0]       cfg_d;
	logic [7:0]       cfg_view;

	logic             low_q;
	logic             low_d;
	logic             high_q;
	logic             high_d;
	logic             fail_q;
	logic             fail_d;
	logic [7:0]       status_view;

	fmc_rd_state_type rd_state_q;
	fmc_rd_state_type rd_state_d;
	logic [7:0]       snap_q;
	logic [7:0]       snap_d;
	logic             clr_pulse;

	logic [7:0]       rdata_q;
	logic [7:0]       rdata_d;

	logic [7:0]       rtemp_q;
	logic [7:0]       rtemp_d;
	logic             ovr_n_q;
	logic             ovr_n_d;
	logic             ovr_oe_q;
	logic             ovr_oe_d;
	logic             thermal_out_n_n_q;
	logic             thermal_out_n_n_d;
	logic             alert_n_q;
	logic             alert_n_d;

	logic             wr_cfg;
	logic             rd_status;
	logic             thermal_out_n_flag;
	logic             tach_tick;
	logic [7:0]       remote_eff;

	fmc_hyst_if       hyst_bus ();

	// ****************************************
	// Decode
	// ****************************************
	assign wr_cfg    = reg_wr && (reg_addr == FMC_ADDR_CONFIG4);
	assign rd_status = reg_rd && (reg_addr == FMC_ADDR_STATUS1);

	// ****************************************
	// Configuration register
	// ****************************************
	// Only bits 7..4 hold state; the low nibble is a fixed pattern
	always_comb begin
		cfg_d = cfg_q;
		if (soft_reset) begin
			cfg_d = FMC_CONFIG4_RST[7:4];
		end else if (wr_cfg) begin
			cfg_d = reg_wdata[7:4];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_q <= FMC_CONFIG4_RST[7:4];
		end else begin
			cfg_q <= cfg_d;
		end
	end

	assign cfg_view = {cfg_q, FMC_CFG_FIXED};

	// ****************************************
	// Status read tracking
	// ****************************************
	// The snapshot records which bits the host saw, so a clear at
	// the end of the byte only drops those and keeps later events.
	always_comb begin
		rd_state_d = rd_state_q;
		snap_d     = snap_q;
		clr_pulse  = 1'b0;
		case (rd_state_q)
			FMC_RD_IDLE: begin
				if (rd_status && !soft_reset) begin
					rd_state_d = FMC_RD_PEND;
					snap_d     = status_view;
				end
			end
			FMC_RD_PEND: begin
				if (soft_reset) begin
					rd_state_d = FMC_RD_IDLE;
					snap_d     = FMC_STATUS1_RST;
				end else if (reg_rd_done) begin
					rd_state_d = FMC_RD_IDLE;
					clr_pulse  = 1'b1;
				end
			end
			default: begin
				rd_state_d = FMC_RD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_state_q <= FMC_RD_IDLE;
			snap_q     <= FMC_STATUS1_RST;
		end else begin
			rd_state_q <= rd_state_d;
			snap_q     <= snap_d;
		end
	end

	// ****************************************
	// Status flags
	// ****************************************
	always_comb begin
		low_d  = low_q;
		high_d = high_q;
		fail_d = fail_q;
		if (soft_reset) begin
			low_d  = FMC_STATUS1_RST[FMC_ST_LOW_BIT];
			high_d = FMC_STATUS1_RST[FMC_ST_HIGH_BIT];
			fail_d = FMC_STATUS1_RST[FMC_ST_FAIL_BIT];
		end else begin
			// Clear first, then set, so a new event wins
			if (clr_pulse && snap_q[FMC_ST_LOW_BIT]) begin
				low_d = 1'b0;
			end
			if (clr_pulse && snap_q[FMC_ST_HIGH_BIT]) begin
				high_d = 1'b0;
			end
			if (monitor_cycle &&
			    $signed(local_temp) <= $signed(local_low_limit)) begin
				low_d = 1'b1;
			end
			if (monitor_cycle &&
			    $signed(local_temp) >= $signed(local_high_limit)) begin
				high_d = 1'b1;
			end
			// Failure flag is only ever set here; only a soft or async reset clears it
			if (monitor_cycle && remote_sensor_fault) begin
				fail_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			low_q  <= FMC_STATUS1_RST[FMC_ST_LOW_BIT];
			high_q <= FMC_STATUS1_RST[FMC_ST_HIGH_BIT];
			fail_q <= FMC_STATUS1_RST[FMC_ST_FAIL_BIT];
		end else begin
			low_q  <= low_d;
			high_q <= high_d;
			fail_q <= fail_d;
		end
	end

	// Bits 3..0 belong to other logic and read as zero here
	always_comb begin
		status_view                   = FMC_STATUS1_RST;
		status_view[FMC_ST_LOW_BIT]   = low_q;
		status_view[FMC_ST_HIGH_BIT]  = high_q;
		status_view[FMC_ST_FAIL_BIT]  = fail_q;
		status_view[FMC_ST_THERMAL_OUT_N_BIT] = thermal_out_n_flag;
	end

	// ****************************************
	// Remote thermal flag with hysteresis
	// ****************************************
	// Compares use the forced value once fail_q is set; the first fault cycle still compares the measurement
	assign remote_eff     = fail_q ? FMC_TEMP_FAILED : remote_temp_meas;
	assign hyst_bus.temp  = remote_eff;
	assign hyst_bus.limit = remote_thermal_out_n_limit;
	assign hyst_bus.cycle = monitor_cycle;
	assign hyst_bus.clr   = clr_pulse && snap_q[FMC_ST_THERMAL_OUT_N_BIT];
	assign hyst_bus.srst  = soft_reset;
	assign thermal_out_n_flag     = hyst_bus.flag;

	fmc_thermal_out_n_hyst u_thermal_out_n_hyst (
		.clk    (clk),
		.arst_n (arst_n),
		.hif    (hyst_bus.hyst)
	);

	// ****************************************
	// Tach refresh timer
	// ****************************************
	fmc_tach_timer #(
		.FAST_CYC (FAST_SPEED_REFRESH_CYC),
		.SLOW_CYC (TACH_SLOW_CYC)
	) u_tach_timer (
		.clk    (clk),
		.arst_n (arst_n),
		.srst   (soft_reset),
		.fast   (cfg_q[FMC_CFG_FAST_BIT-4]),
		.tick   (tach_tick)
	);

	// ****************************************
	// Read data
	// ****************************************
	// Unmapped addresses return zero; data holds until the next read
	always_comb begin
		rdata_d = rdata_q;
		if (reg_rd) begin
			case (reg_addr)
				FMC_ADDR_STATUS1: rdata_d = status_view;
				FMC_ADDR_CONFIG4: rdata_d = cfg_view;
				default:          rdata_d = FMC_RDATA_NONE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= FMC_RDATA_NONE;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// ****************************************
	// Pins and remote data
	// ****************************************
	// Failure pins follow the flag next value so they move with the bit;
	// the thermal pin is registered from its flag and lags it one edge
	always_comb begin
		rtemp_d = rtemp_q;
		if (fail_d) begin
			rtemp_d = FMC_TEMP_FAILED;
		end else if (monitor_cycle) begin
			rtemp_d = remote_temp_meas;
		end
		ovr_oe_d  = cfg_d[FMC_CFG_OVR_BIT-4];
		ovr_n_d   = !fail_d;
		thermal_out_n_n_d = !hyst_bus.flag;
		alert_n_d = !((fail_q && sensor_fail_irq_en) ||
		              (thermal_out_n_flag && thermal_over_irq_en));
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rtemp_q   <= FMC_STATUS1_RST;
			ovr_oe_q  <= FMC_CONFIG4_RST[FMC_CFG_OVR_BIT];
			ovr_n_q   <= 1'b1;
			thermal_out_n_n_q <= 1'b1;
			alert_n_q <= 1'b1;
		end else begin
			rtemp_q   <= rtemp_d;
			ovr_oe_q  <= ovr_oe_d;
			ovr_n_q   <= ovr_n_d;
			thermal_out_n_n_q <= thermal_out_n_n_d;
			alert_n_q <= alert_n_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign reg_rdata          = rdata_q;
	assign remote_temp_data   = rtemp_q;
	assign pulses_per_rev_sel = cfg_q[FMC_CFG_PPR_BIT-4];
	assign fast_speed_refresh = cfg_q[FMC_CFG_FAST_BIT-4];
	assign tach_update        = tach_tick;
	assign overtemp_out_n     = ovr_n_q;
	assign overtemp_out_oe    = ovr_oe_q;
	assign thermal_out_n      = thermal_out_n_n_q;
	assign alert_n            = alert_n_q;

endmodule
`default_nettype wire

// file: verification/fan_monitor_config_status_test.sv
`timescale 1ns/10ps
`default_nettype none
module fan_monitor_config_status_test;
	import fmc_pkg::*;
	localparam int FAST = 20;
	localparam int SLOW = 80;
	logic       clk = 1'b0;
	logic       arst_n = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, remote_temp_data;
	logic [7:0] local_temp, local_low_limit, local_high_limit;
	logic [7:0] remote_temp_meas, remote_thermal_out_n_limit;
	logic       reg_wr, reg_rd, reg_rd_done, soft_reset, monitor_cycle;
	logic       remote_sensor_fault, sensor_fail_irq_en, thermal_over_irq_en;
	logic       pulses_per_rev_sel, fast_speed_refresh, tach_update;
	logic       overtemp_out_n, overtemp_out_oe, thermal_out_n, alert_n;
	int         failures = 0;
	int         check_count = 0;
	int         cyc = 0;
	int         n;

	always #12.5 clk = ~clk;

	fmc_host_model i_host (.clk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata,
		.reg_rd, .reg_rd_done);
	fmc_top #(.FAST_SPEED_REFRESH_CYC(FAST), .TACH_SLOW_CYC(SLOW)) i_dut (
		.clk, .arst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rd_done,
		.reg_rdata, .soft_reset, .monitor_cycle, .local_temp, .local_low_limit,
		.local_high_limit, .remote_temp_meas, .remote_thermal_out_n_limit,
		.remote_sensor_fault, .sensor_fail_irq_en, .thermal_over_irq_en,
		.remote_temp_data, .pulses_per_rev_sel, .fast_speed_refresh,
		.tach_update, .overtemp_out_n, .overtemp_out_oe, .thermal_out_n,
		.alert_n);

	task automatic give_verdict();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			give_verdict();
		end
	end

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask

	task automatic rdchk(input logic [7:0] a, input int lag,
		input logic [7:0] e);
		logic [7:0] d;
		i_host.rd(a, lag, d);
		chk8(d, e);
	endtask

	task automatic mon(input logic [7:0] lt, ll, lh, rt, input logic f);
		@(posedge clk);
		local_temp          <= lt;
		local_low_limit     <= ll;
		local_high_limit    <= lh;
		remote_temp_meas    <= rt;
		remote_sensor_fault <= f;
		monitor_cycle       <= 1'b1;
		@(posedge clk);
		monitor_cycle       <= 1'b0;
	endtask

	// Quiet local limits so only the remote flags can move
	task automatic thm(input logic [7:0] rt, input logic f);
		mon(8'h19, 8'h80, 8'h7f, rt, f);
	endtask

	function automatic logic [7:0] loc_exp(input logic [7:0] lt, ll, lh);
		return {$signed(lt) <= $signed(ll), $signed(lt) >= $signed(lh), 6'h00};
	endfunction

	task automatic period();
		n = 0;
		do @(negedge clk); while (tach_update !== 1'b1);
		do begin
			@(negedge clk);
			n++;
		end while (tach_update !== 1'b1 && n < 1000);
	endtask

	initial begin
		logic [7:0] w, lt, ll, lh;
		{local_temp, local_low_limit, local_high_limit} = 24'h0;
		{remote_temp_meas, remote_thermal_out_n_limit} = {8'h00, 8'h32};
		{soft_reset, monitor_cycle, remote_sensor_fault} = 3'b000;
		{sensor_fail_irq_en, thermal_over_irq_en} = 2'b00;
		void'($urandom(32'h271e2bd1));
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		rdchk(8'h04, -1, FMC_CONFIG4_RST);
		rdchk(8'h02, 0, FMC_STATUS1_RST);
		chk1(overtemp_out_oe, 1'b0);
		chk1(pulses_per_rev_sel, 1'b0);
		chk1(fast_speed_refresh, 1'b0);
		$display("test reset done");

		for (int i = 0; i < 10; i++) begin
			w = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
			i_host.setup(w);
			i_host.wr(8'h02, ~w);
			rdchk(8'h04, -1, {1'b1, w[6:4], 4'h8});
			chk1(pulses_per_rev_sel, w[6]);
			chk1(fast_speed_refresh, w[5]);
			chk1(overtemp_out_oe, w[4]);
		end
		rdchk(8'h3f, -1, FMC_RDATA_NONE);
		i_host.wr(8'h04, 8'h07);
		rdchk(8'h04, -1, 8'h08);
		$display("test config done");

		i_host.setup(8'h20);
		period();
		chk8(8'(n), 8'(FAST));
		i_host.setup(8'h00);
		period();
		chk8(8'(n), 8'(SLOW));
		$display("test tach done");

		for (int i = 0; i < 8; i++) begin
			lt = 8'($urandom);
			ll = (i == 0) ? lt : 8'($urandom);
			lh = (i == 0) ? lt : 8'($urandom);
			mon(lt, ll, lh, 8'h00, 1'b0);
			rdchk(8'h02, -1, loc_exp(lt, ll, lh));
			fork
				mon(lt, ll, lh, 8'h00, 1'b0);
				i_host.done();
			join
			rdchk(8'h02, 0, loc_exp(lt, ll, lh));
			rdchk(8'h02, 0, 8'h00);
		end
		$display("test local done");

		thm(8'h3c, 1'b0);
		// Thermal pin is registered from the flag, one edge behind it
		repeat (2) @(negedge clk);
		chk1(thermal_out_n, 1'b0);
		chk8(remote_temp_data, 8'h3c);
		@(negedge clk);
		chk1(alert_n, 1'b1);
		@(posedge clk);
		thermal_over_irq_en <= 1'b1;
		repeat (2) @(negedge clk);
		chk1(alert_n, 1'b0);
		rdchk(8'h02, 0, 8'h10);
		// Each read is finished so the next one takes a fresh snapshot
		rdchk(8'h02, 0, 8'h00);
		chk1(thermal_out_n, 1'b1);
		thm(8'h3c, 1'b0);
		rdchk(8'h02, 0, 8'h00);
		thm(8'h2e, 1'b0);
		rdchk(8'h02, 0, 8'h00);
		thm(8'h2d, 1'b0);
		thm(8'h3c, 1'b0);
		rdchk(8'h02, 0, 8'h10);
		$display("test thermal done");

		@(posedge clk);
		sensor_fail_irq_en <= 1'b1;
		thm(8'h00, 1'b1);
		repeat (2) @(negedge clk);
		chk1(overtemp_out_n, 1'b0);
		chk8(remote_temp_data, FMC_TEMP_FAILED);
		chk1(alert_n, 1'b0);
		thm(8'h00, 1'b0);
		rdchk(8'h02, 0, 8'h20);
		rdchk(8'h02, 0, 8'h20);
		@(posedge clk);
		soft_reset <= 1'b1;
		@(posedge clk);
		soft_reset <= 1'b0;
		repeat (2) @(negedge clk);
		chk1(overtemp_out_n, 1'b1);
		rdchk(8'h02, -1, 8'h00);
		rdchk(8'h04, -1, FMC_CONFIG4_RST);
		$display("test failure done");
		give_verdict();
	end
endmodule
`default_nettype wire

// file: verification/fmc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module fmc_host_model (
	input  wire logic       clk,        // Clock
	input  wire logic [7:0] reg_rdata,  // Read data
	output var  logic [7:0] reg_addr,   // Address
	output var  logic       reg_wr,     // Write
	output var  logic [7:0] reg_wdata,  // Write data
	output var  logic       reg_rd,     // Read
	output var  logic       reg_rd_done // Byte returned
);
	initial begin
		reg_addr    = 8'h00;
		reg_wr      = 1'b0;
		reg_wdata   = 8'h00;
		reg_rd      = 1'b0;
		reg_rd_done = 1'b0;
	end

	// Released lines show inverted values so stale data is never trusted
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask

	task automatic setup(input logic [7:0] cfg);
		wr(8'h04, cfg | 8'h80);
	endtask

	task automatic done();
		@(posedge clk);
		reg_rd_done <= 1'b1;
		@(posedge clk);
		reg_rd_done <= 1'b0;
	endtask

	// A negative lag leaves the byte unacknowledged
	task automatic rd(input logic [7:0] a, input int lag,
		output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		reg_addr <= ~a;
		@(negedge clk);
		d = reg_rdata;
		if (lag >= 0) begin
			repeat (lag) @(posedge clk);
			done();
		end
	endtask
endmodule
`default_nettype wire

// file: verification/fmc_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module fmc_top_asserts
	import fmc_pkg::*;
#(
	parameter int FAST_SPEED_REFRESH_CYC = FMC_FAST_SPEED_REFRESH_CYC,
	parameter int TACH_SLOW_CYC = FMC_TACH_SLOW_CYC
) (
	input wire logic       clk,                 // Clock
	input wire logic       arst_n,              // Reset
	input wire logic [7:0] reg_addr,            // Address
	input wire logic       reg_wr,              // Write
	input wire logic [7:0] reg_wdata,           // Write data
	input wire logic       reg_rd,              // Read
	input wire logic [7:0] reg_rdata,           // Read data
	input wire logic       soft_reset,          // Soft reset
	input wire logic       monitor_cycle,       // Compare strobe
	input wire logic [7:0] local_temp,          // Local temp
	input wire logic [7:0] local_low_limit,     // Low limit
	input wire logic [7:0] local_high_limit,    // High limit
	input wire logic [7:0] remote_temp_meas,    // Remote temp
	input wire logic [7:0] remote_thermal_out_n_limit,  // Remote limit
	input wire logic       remote_sensor_fault, // Sensor fault
	input wire logic       sensor_fail_irq_en,  // Fail enable
	input wire logic       thermal_over_irq_en, // Thermal enable
	input wire logic [7:0] remote_temp_data,    // Remote data
	input wire logic       pulses_per_rev_sel,  // Pulses select
	input wire logic       tach_update,         // Tach pulse
	input wire logic       overtemp_out_n,      // Over-temp pin
	input wire logic       overtemp_out_oe,     // Over-temp enable
	input wire logic       thermal_out_n,       // Thermal pin
	input wire logic       alert_n              // Alert pin
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	wire logic wr4 = reg_wr && reg_addr == FMC_ADDR_CONFIG4 && !soft_reset;
	wire logic rd4 = reg_rd && reg_addr == FMC_ADDR_CONFIG4;
	wire logic rd2 = reg_rd && reg_addr == FMC_ADDR_STATUS1 && !soft_reset;
	logic [1:0] sr_q;
	logic [1:0] sr_d;
	int         gap_q;
	int         gap_d;
	// Pins lag a soft reset, so skip two edges after one
	wire logic calm = !soft_reset && sr_q == 2'b00;

	always_comb begin
		sr_d  = {sr_q[0], soft_reset};
		gap_d = (tach_update || soft_reset) ? 0 : gap_q + 1;
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sr_q  <= 2'b00;
			gap_q <= 0;
		end else begin
			sr_q  <= sr_d;
			gap_q <= gap_d;
		end
	end

	AST_CFG_PPR: assert property (
		wr4 |=> pulses_per_rev_sel == $past(reg_wdata[6]))
		else $error("pulses select not taken from write");
	AST_CFG_OE: assert property (
		wr4 |=> overtemp_out_oe == $past(reg_wdata[4]))
		else $error("over-temp enable not taken from write");
	AST_CFG_FIXED: assert property (
		rd4 |=> reg_rdata[3:0] == FMC_CFG_FIXED)
		else $error("fixed config bits wrong");
	AST_LOW_SET: assert property (
		monitor_cycle && !soft_reset &&
		$signed(local_temp) <= $signed(local_low_limit)
		##1 !soft_reset ##1 rd2 |=> reg_rdata[7])
		else $error("low flag missing");
	AST_HIGH_SET: assert property (
		monitor_cycle && !soft_reset &&
		$signed(local_temp) >= $signed(local_high_limit)
		##1 !soft_reset ##1 rd2 |=> reg_rdata[6])
		else $error("high flag missing");
	AST_FAIL_SET: assert property (
		monitor_cycle && remote_sensor_fault && !soft_reset
		|=> !overtemp_out_n ##1 remote_temp_data == FMC_TEMP_FAILED)
		else $error("sensor failure not shown");
	AST_FAIL_HOLD: assert property (
		!overtemp_out_n && calm |=> !overtemp_out_n)
		else $error("sensor failure flag dropped");
	AST_FAIL_ALERT: assert property (
		!overtemp_out_n && sensor_fail_irq_en && calm |=> !alert_n)
		else $error("failure alert missing");
	AST_ALERT_CAUSE: assert property (
		!alert_n && calm |-> $past(!overtemp_out_n && sensor_fail_irq_en)
		|| (!thermal_out_n && $past(thermal_over_irq_en)))
		else $error("alert without enabled cause");
	AST_THERMAL_OUT_N_CAUSE: assert property (
		$fell(thermal_out_n) |-> $past(monitor_cycle &&
		$signed(remote_temp_meas) > $signed(remote_thermal_out_n_limit), 2))
		else $error("thermal pin low without cause");
	AST_TACH_GAP: assert property (
		gap_q <= TACH_SLOW_CYC + 1)
		else $error("tach refresh overdue");
endmodule

bind fmc_top fmc_top_asserts #(
	.FAST_SPEED_REFRESH_CYC(FAST_SPEED_REFRESH_CYC),
	.TACH_SLOW_CYC(TACH_SLOW_CYC)
) i_asserts (
	.clk, .arst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
	.soft_reset, .monitor_cycle, .local_temp, .local_low_limit,
	.local_high_limit, .remote_temp_meas, .remote_thermal_out_n_limit,
	.remote_sensor_fault, .sensor_fail_irq_en, .thermal_over_irq_en,
	.remote_temp_data, .pulses_per_rev_sel, .tach_update, .overtemp_out_n,
	.overtemp_out_oe, .thermal_out_n, .alert_n
);
`default_nettype wire
